// file: shared/adc_config_consts.vh
// Purpose: Offsets, field positions, reset values and mode codes
//          for the ADC volume, phase and left AGC configuration block.
// Assumes: Register addresses are page 0 register numbers.
// Notes:   Definitions only.
`ifndef ADC_CONFIG_CONSTS_VH
`define ADC_CONFIG_CONSTS_VH

// Register addresses
`define RIGHT_CHANNEL_DIGITAL_GAIN_ADDR 7'h54
`define STEREO_PHASE_OFFSET_ADDR        7'h55
`define LEFT_AGC_ENABLE_TARGET_ADDR     7'h56
`define LEFT_AGC_HYST_NOISE_CLIP_ADDR   7'h57

// Reset values
`define RIGHT_CHANNEL_DIGITAL_GAIN_RST  8'h00
`define STEREO_PHASE_OFFSET_RST         8'h00
`define LEFT_AGC_ENABLE_TARGET_RST      8'h00
`define LEFT_AGC_HYST_NOISE_CLIP_RST    8'h00

// Datapath output reset values, the decode of all-zero registers
`define AGC_TARGET_HALF_DB_RST          8'hf5
`define HYST_DB_RST                     3'h1

// Writable bit masks; the rest read as zero
`define RIGHT_GAIN_WMASK                8'h7f
`define AGC_ENABLE_TARGET_WMASK         8'hf0

// Field positions
`define AGC_ENABLE_BIT                  7
`define AGC_TARGET_MSB                  6
`define AGC_TARGET_LSB                  4
`define AGC_HYST_MSB                    7
`define AGC_HYST_LSB                    6
`define AGC_NOISE_MSB                   5
`define AGC_NOISE_LSB                   1
`define AGC_CLIP_BIT                    0

// Volume code limits, two's complement half-dB steps
`define GAIN_ZERO_BAND_LO               7'h40
`define GAIN_LOWEST_CODE                7'h68
`define GAIN_HIGHEST_CODE               7'h28

// Soft-stepping modes
`define STEP_EVERY_SAMPLE               2'h0
`define STEP_EVERY_TWO                  2'h1
`define STEP_DISABLED                   2'h2

// Hysteresis code that turns hysteresis off
`define HYST_OFF_CODE                   2'h3

// Noise threshold base in dB; code one lands 2 dB below it
`define NOISE_BASE_DB                   8'he4

`endif

// file: rtl/gain_soft_stepper.v
// Purpose: Walks the applied gain code toward its target in half-dB steps.
// Assumes: sampleTick is a one-cycle pulse at the sample rate.
// Notes:   Reserved mode 11 is treated as stepping disabled.
`timescale 1ns/100ps
`default_nettype none
`include "adc_config_consts.vh"

module gain_soft_stepper (
  input  wire       clock,
  input  wire       resetn,
  input  wire       sampleTick,
  input  wire [1:0] stepMode,
  input  wire [6:0] targetGain,
  output reg  [6:0] appliedGain
);

  reg halfRate; // Toggles each sample, paces the every-two mode

  wire stepNow = sampleTick &
                 ((stepMode == `STEP_EVERY_SAMPLE) |
                  ((stepMode == `STEP_EVERY_TWO) & halfRate));
  wire jumpNow = sampleTick & (stepMode[1] == 1'b1);

  // One step per allowed tick, or an immediate jump
  always @(posedge clock) begin
    if (!resetn) begin
      appliedGain <= 7'h00;
      halfRate    <= 1'b0;
    end else begin
      if (sampleTick)
        halfRate <= ~halfRate;
      if (jumpNow)
        appliedGain <= targetGain;
      else if (stepNow) begin
        // Signed compare; step by one code toward the target
        if ($signed(appliedGain) < $signed(targetGain))
          appliedGain <= appliedGain + 7'h01;
        else if ($signed(appliedGain) > $signed(targetGain))
          appliedGain <= appliedGain - 7'h01;
      end
    end
  end

endmodule // gain_soft_stepper
`default_nettype wire

// file: rtl/adc_volume_phase_agc_config.v
// Purpose: Register bank and sample-aligned settings for the right
//          channel digital volume, stereo phase offset and left AGC.
// Assumes: Control port writes come from the control interface logic on
//          this clock; sampleStrobe is a one-cycle pulse per sample.
// Notes:   Settings reach the datapath only on sampleStrobe.
//          Reserved volume codes pass through unchanged; software
//          must keep clear of them.
//          A read and a write in one cycle return the old value.
`timescale 1ns/100ps
`default_nettype none
`include "adc_config_consts.vh"

module adc_volume_phase_agc_config (
  input  wire       clock,
  input  wire       resetn,
  // Control port
  input  wire [6:0] regAddr,
  input  wire       regWrite,
  input  wire [7:0] regWriteData,
  input  wire       regRead,
  output reg  [7:0] regReadData,
  // Sample timing and soft-step mode
  input  wire       sampleStrobe,
  input  wire [1:0] softStepMode,
  // Settings for the datapath
  output wire [6:0] rightGainCode,
  output reg  [7:0] phaseOffset,
  output reg        agcEnable,
  output reg  [7:0] agcTargetHalfDb,
  output reg        hystEnable,
  output reg  [2:0] hystDb,
  output reg        noiseDetectEnable,
  output reg  [7:0] noiseThresholdDb,
  output reg        clipStepEnable
);

  // Software-visible registers
  // Raw bytes only; decoding waits for the sample strobe
  reg  [7:0] rightChannelDigitalGain; // Volume register, bit 7 held zero
  reg  [7:0] stereoPhaseOffset;       // Signed phase count
  reg  [7:0] leftAgcEnableTarget;     // Enable and target, low nibble zero
  reg  [7:0] leftAgcHystNoiseClip;    // Hysteresis, noise, clip stepping

  // Sample-aligned gain target handed to the soft stepper
  // Kept apart from the register so a mid-sample write cannot reach it
  reg  [6:0] gainTarget;

  // Maps a volume code onto the applied half-dB gain
  function [6:0] mapVolume;
    input [6:0] code;
    begin
      // Upper negative band below -12 dB does not attenuate
      if (code >= `GAIN_ZERO_BAND_LO && code < `GAIN_LOWEST_CODE)
        mapVolume = 7'h00;
      else
        // 0x68 and up: -12 to -0.5 dB; up to 0x28: 0 to +20 dB
        // Reserved codes are not trapped here
        mapVolume = code;
    end
  endfunction

  // Target level code to half-dB level, signed
  // Half-dB units keep the -5.5 dB level exact
  function [7:0] targetLevel;
    input [2:0] code;
    begin
      case (code)
        3'h0:    targetLevel = 8'hf5; // -5.5 dB
        3'h1:    targetLevel = 8'hf0; // -8 dB
        3'h2:    targetLevel = 8'hec; // -10 dB
        3'h3:    targetLevel = 8'he8; // -12 dB
        3'h4:    targetLevel = 8'he4; // -14 dB
        3'h5:    targetLevel = 8'hde; // -17 dB
        3'h6:    targetLevel = 8'hd8; // -20 dB
        default: targetLevel = 8'hd0; // -24 dB
      endcase
    end
  endfunction

  // Hysteresis code to dB, zero when off
  // Codes 00, 01, 10 give 1, 2, 4 dB; 11 gives zero
  function [2:0] hystLevel;
    input [1:0] code;
    begin
      case (code)
        2'h0:    hystLevel = 3'h1;
        2'h1:    hystLevel = 3'h2;
        2'h2:    hystLevel = 3'h4;
        default: hystLevel = 3'h0;
      endcase
    end
  endfunction

  // Field slices of the AGC registers
  wire [2:0] targetField =
    leftAgcEnableTarget[`AGC_TARGET_MSB:`AGC_TARGET_LSB];
  wire [1:0] hystField   = leftAgcHystNoiseClip[`AGC_HYST_MSB:`AGC_HYST_LSB];
  wire [4:0] noiseField  = leftAgcHystNoiseClip[`AGC_NOISE_MSB:`AGC_NOISE_LSB];

  // Threshold falls 2 dB per code from -30 dB at code one
  // Code 31 lands on -90 dB, which still fits eight signed bits
  wire [7:0] noiseLevel = `NOISE_BASE_DB - {2'h0, noiseField, 1'b0};

  // Register writes; reserved bits are masked so they stay zero
  // Writes to unmapped addresses fall to the default branch
  always @(posedge clock) begin
    if (!resetn) begin
      // All four registers clear on reset
      rightChannelDigitalGain <= `RIGHT_CHANNEL_DIGITAL_GAIN_RST;
      stereoPhaseOffset       <= `STEREO_PHASE_OFFSET_RST;
      leftAgcEnableTarget     <= `LEFT_AGC_ENABLE_TARGET_RST;
      leftAgcHystNoiseClip    <= `LEFT_AGC_HYST_NOISE_CLIP_RST;
    end else if (regWrite) begin
      case (regAddr)
        `RIGHT_CHANNEL_DIGITAL_GAIN_ADDR: begin
          // Top bit ignored on write
          rightChannelDigitalGain <= regWriteData & `RIGHT_GAIN_WMASK;
        end
        `STEREO_PHASE_OFFSET_ADDR: begin
          // Whole byte is the signed count
          stereoPhaseOffset <= regWriteData;
        end
        `LEFT_AGC_ENABLE_TARGET_ADDR: begin
          // Low nibble reserved; mask keeps it zero
          leftAgcEnableTarget <= regWriteData & `AGC_ENABLE_TARGET_WMASK;
        end
        `LEFT_AGC_HYST_NOISE_CLIP_ADDR: begin
          // Every bit of this register is writable
          leftAgcHystNoiseClip <= regWriteData;
        end
        default: begin
          // Unmapped addresses are ignored
        end
      endcase
    end
  end

  // Read data is registered; unmapped addresses read zero
  // Data holds until the next read, so it may be sampled late
  always @(posedge clock) begin
    if (!resetn) begin
      regReadData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        // Volume, top bit always zero
        `RIGHT_CHANNEL_DIGITAL_GAIN_ADDR:
          regReadData <= rightChannelDigitalGain;
        // Phase count, read back whole
        `STEREO_PHASE_OFFSET_ADDR:
          regReadData <= stereoPhaseOffset;
        // AGC enable and target, low nibble zero
        `LEFT_AGC_ENABLE_TARGET_ADDR:
          regReadData <= leftAgcEnableTarget;
        // Hysteresis, noise and clip stepping
        `LEFT_AGC_HYST_NOISE_CLIP_ADDR:
          regReadData <= leftAgcHystNoiseClip;
        default:
          regReadData <= 8'h00;
      endcase
    end
  end

  // Datapath settings change only at a sample boundary, so a sample never
  // sees a half-written setting; costs up to one sample of latency
  always @(posedge clock) begin
    if (!resetn) begin
      // Outputs match the decode of all-zero registers
      gainTarget        <= 7'h00;
      phaseOffset       <= `STEREO_PHASE_OFFSET_RST;
      agcEnable         <= 1'b0;
      agcTargetHalfDb   <= `AGC_TARGET_HALF_DB_RST;
      hystEnable        <= 1'b1;
      hystDb            <= `HYST_DB_RST;
      noiseDetectEnable <= 1'b0;
      noiseThresholdDb  <= 8'h00;
      clipStepEnable    <= 1'b0;
    end else if (sampleStrobe) begin
      // Gain goes to the stepper, not straight to the output
      gainTarget <= mapVolume(rightChannelDigitalGain[6:0]);
      // Positive delays the left channel behind the right
      phaseOffset <= stereoPhaseOffset;
      agcEnable   <= leftAgcEnableTarget[`AGC_ENABLE_BIT];
      agcTargetHalfDb <= targetLevel(targetField);
      // Hysteresis code 11 turns hysteresis off
      hystEnable  <= (hystField != `HYST_OFF_CODE);
      hystDb      <= hystLevel(hystField);
      // Noise code zero disables detection
      noiseDetectEnable <= (noiseField != 5'h00);
      // Zero code reports no threshold at all
      if (noiseField == 5'h00)
        noiseThresholdDb <= 8'h00;
      else
        noiseThresholdDb <= noiseLevel;
      clipStepEnable <= leftAgcHystNoiseClip[`AGC_CLIP_BIT];
    end
  end

  // Soft stepping of the applied right-channel gain
  // The stepper uses the target of the previous strobe, so a new
  // volume starts moving one sample after it is latched
  gain_soft_stepper stepper (
    .clock       (clock),
    .resetn      (resetn),
    .sampleTick  (sampleStrobe),
    .stepMode    (softStepMode),
    .targetGain  (gainTarget),
    .appliedGain (rightGainCode)
  );

endmodule // adc_volume_phase_agc_config
`default_nettype wire

// file: dv/adc_config_properties.sv
// Purpose: Port assertions for the volume, phase and AGC settings block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to the design from the testbench top file.
`timescale 1ns/100ps
`default_nettype none
module adc_config_properties (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic [6:0] regAddr,
  input wire logic       regWrite,
  input wire logic [7:0] regWriteData,
  input wire logic       regRead,
  input wire logic [7:0] regReadData,
  input wire logic       sampleStrobe,
  input wire logic [1:0] softStepMode,
  input wire logic [6:0] rightGainCode,
  input wire logic [7:0] phaseOffset,
  input wire logic       agcEnable,
  input wire logic [7:0] agcTargetHalfDb,
  input wire logic       hystEnable,
  input wire logic [2:0] hystDb,
  input wire logic       noiseDetectEnable,
  input wire logic [7:0] noiseThresholdDb,
  input wire logic       clipStepEnable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Write to a place, then read it straight back
  sequence wr_rd(a);
    regWrite && regAddr == a ##1 regRead && !regWrite && regAddr == a;
  endsequence
  // Write to a place, then a strobe with no write beside it
  sequence wr_st(a);
    regWrite && regAddr == a ##1 sampleStrobe && !regWrite;
  endsequence
  hold_settings_a: assert property (
    !sampleStrobe |=> $stable({rightGainCode, phaseOffset, agcEnable,
      agcTargetHalfDb, hystDb, noiseThresholdDb, clipStepEnable}))
    else $error("settings moved without a strobe");
  gain_band_a: assert property (
    !(rightGainCode inside {[7'h40:7'h67]})) else $error("gain in zero band");
  gain_step_a: assert property (
    sampleStrobe && !softStepMode[1] |=> 7'(rightGainCode -
      $past(rightGainCode)) inside {7'h0, 7'h1, 7'h7f})
    else $error("soft step larger than one code");
  gain_mask_a: assert property (
    wr_rd(7'h54) |=> regReadData == ($past(regWriteData, 2) & 8'h7f))
    else $error("volume top bit not dropped");
  agc_mask_a: assert property (
    wr_rd(7'h56) |=> regReadData == ($past(regWriteData, 2) & 8'hf0))
    else $error("agc control readback wrong");
  phase_rw_a: assert property (
    wr_rd(7'h55) |=> regReadData == $past(regWriteData, 2))
    else $error("phase readback wrong");
  clip_latch_a: assert property (
    wr_st(7'h57) |=> clipStepEnable == $past(regWriteData[0], 2) &&
      hystEnable == ($past(regWriteData[7:6], 2) != 2'h3))
    else $error("clip or hysteresis not latched");
  noise_pair_a: assert property (
    noiseDetectEnable == (noiseThresholdDb != 8'h0))
    else $error("noise enable and threshold disagree");
endmodule // adc_config_properties
`default_nettype wire

// file: dv/testbench.sv
// Purpose: Self-checking bench for the volume, phase and AGC block.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Drivers queue expectations; a monitor pops and compares.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clock = 0, resetn = 0, regWrite = 0, regRead = 0, sampleStrobe = 0;
  logic [6:0] regAddr = 7'h0, rightGainCode;
  logic [7:0] regWriteData = 8'h0, regReadData, phaseOffset;
  logic [7:0] agcTargetHalfDb, noiseThresholdDb, g, p, t, h;
  logic [1:0] softStepMode = 2'h2;
  logic agcEnable, hystEnable, noiseDetectEnable, clipStepEnable;
  logic [2:0] hystDb;
  logic rdSeen = 0, stSeen = 0, chkSt = 0;
  logic [37:0] rq[$], sq[$], ex;
  logic [31:0] seed = 32'h56;
  int mismatches = 0, n_checks = 0, cycles = 0;
  adc_volume_phase_agc_config adc_volume_phase_agc_config_inst (.*);
  // Decoded outputs in the order expv builds them
  wire [37:0] seen = {rightGainCode, phaseOffset, agcEnable,
    agcTargetHalfDb, hystEnable, hystDb, noiseDetectEnable,
    noiseThresholdDb, clipStepEnable};
  always #50 clock = ~clock;
  // Xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Decoded settings expected from raw register bytes
  function automatic logic [37:0] expv(logic [7:0] g, p, t, h);
    logic [7:0] tt[8] = '{8'hf5, 8'hf0, 8'hec, 8'he8, 8'he4, 8'hde, 8'hd8,
                          8'hd0};
    logic [4:0] nz = h[5:1];
    return {(g[6:0] inside {[7'h40:7'h67]}) ? 7'h0 : g[6:0], p, t[7],
      tt[t[6:4]], h[7:6] != 2'h3, h[7:6] == 2'h3 ? 3'h0 : 3'h1 << h[7:6],
      nz != 5'h0, nz == 5'h0 ? 8'h0 : 8'he4 - {nz, 1'b0}, h[0]};
  endfunction
  task automatic check(string n, logic [37:0] s, e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One bus cycle; bus, strobe and check inputs set once per falling edge
  task automatic op(logic w, r, s, c, logic [6:0] a, logic [7:0] d);
    regWrite = w;
    regRead = r;
    sampleStrobe = s;
    chkSt = c;
    regAddr = a;
    regWriteData = d;
    @(negedge clock);
  endtask
  // New volume target, n plain strobes, then a checked strobe
  task automatic steps(logic [6:0] v, int n, logic [6:0] e);
    op(1, 0, 0, 0, 7'h54, {1'b0, v});
    repeat (n) begin
      op(0, 0, 1, 0, 7'h0, 8'h0);
      op(0, 0, 0, 0, 7'h0, 8'h0);
    end
    sq.push_back(expv({1'b0, e}, p, t, h));
    op(0, 0, 1, 1, 7'h0, 8'h0);
    op(0, 0, 0, 0, 7'h0, 8'h0);
  endtask
  // Monitor: results show one edge after the request
  always @(posedge clock) begin
    rdSeen <= regRead && resetn;
    stSeen <= chkSt;
    cycles <= cycles + 1;
  end
  always @(negedge clock) begin
    if (rdSeen) begin
      ex = rq.pop_front();
      check("readData", {30'h0, regReadData}, ex);
    end
    if (stSeen) begin
      ex = sq.pop_front();
      check("settings", seen, ex);
    end
    if (cycles > 3000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    {p, t, h} = 24'h0;
    repeat (10) @(negedge clock);
    resetn = 1;
    // Reset values show at the first edge; an unmapped write must not land
    sq.push_back(expv(8'h0, 8'h0, 8'h0, 8'h0));
    op(1, 0, 0, 1, 7'h58, 8'hff);
    for (int a = 'h53; a < 'h59; a++) begin
      rq.push_back(38'h0);
      op(0, 1, 0, 0, 7'(a), 8'h0);
    end
    steps(7'h0, 1, 7'h0);
    for (int i = 0; i < 40; i++) begin
      {g, p, t, h} = rnd();
      if (g[6:0] inside {[7'h29:7'h3f]}) g[6:0] = 7'h28;
      softStepMode = {1'b1, p[0]};
      op(1, 0, 0, 0, 7'h54, g);
      rq.push_back({30'h0, g & 8'h7f});
      op(0, 1, 0, 0, 7'h54, 8'h0);
      op(1, 0, 0, 0, 7'h55, p);
      rq.push_back({30'h0, p});
      op(0, 1, 0, 0, 7'h55, 8'h0);
      op(1, 0, 0, 0, 7'h56, t);
      rq.push_back({30'h0, t & 8'hf0});
      op(0, 1, 0, 0, 7'h56, 8'h0);
      op(1, 0, 0, 0, 7'h57, h);
      op(0, 0, 1, 0, 7'h0, 8'h0); // Strobe right after the write
      steps(g[6:0], 1, g[6:0]);
    end
    steps(7'h0, 1, 7'h0);
    softStepMode = 2'h0;
    steps(7'h3, 1, 7'h1);
    steps(7'h3, 1, 7'h3);
    steps(7'h7e, 4, 7'h7f);
    softStepMode = 2'h1;
    steps(7'h2, 8, 7'h2);
    softStepMode = 2'h2;
    steps(7'h50, 1, 7'h0);
    steps(7'h68, 1, 7'h68);
    close_out();
  end
endmodule // testbench
bind adc_volume_phase_agc_config adc_config_properties
  adc_config_properties_inst (.*);
`default_nettype wire
